/* File: lcsf_assertions.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker, link 0 and static slot 0 (link c)
// ---------------------------------------------------------------
module lcsf_checker #(
    parameter NLINK = 8,
    parameter GAPW = 11
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire [NLINK-1:0] link_enable_o,
    input wire [NLINK-1:0] pin_mux_sel_o,
    input wire [NLINK-1:0] five_wire_select_o,
    input wire [NLINK-1:0] send_greeting_token_o,
    input wire [NLINK-1:0] credit_clear_o,
    input wire [NLINK-1:0] receiver_restart_o,
    input wire [NLINK*GAPW-1:0] sym_gap_o,
    input wire [NLINK*GAPW-1:0] tok_gap_o,
    input wire [NLINK-1:0] fixed_forward_on_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire w0 = wr_i && addr_i == 8'h80; // link 0 write
    wire s0 = wr_i && addr_i == 8'ha0; // first static slot
    a_link_enable: assert property (
        w0 |-> ##2 link_enable_o[0] == $past(wdata_i[31], 2))
        else $error("link enable wrong");
    a_mux_mirror: assert property (
        pin_mux_sel_o == link_enable_o) else $error("mux wrong");
    a_wire_mode: assert property (
        w0 |-> ##2 five_wire_select_o[0] == $past(wdata_i[30], 2))
        else $error("width wrong");
    a_greet_pulse: assert property (
        w0 && wdata_i[24] |=> send_greeting_token_o[0] &&
        credit_clear_o[0]) else $error("greeting missing");
    a_greet_cause: assert property (
        send_greeting_token_o[0] |-> $past(w0 && wdata_i[24]))
        else $error("stray greeting");
    a_restart_pulse: assert property (
        $rose(receiver_restart_o[0]) |-> $past(w0 && wdata_i[23])
        ##1 !receiver_restart_o[0]) else $error("restart wrong");
    a_symbol_gap: assert property (
        w0 |-> ##2 sym_gap_o[10:0] == $past(wdata_i[21:11], 2))
        else $error("symbol gap wrong");
    a_token_gap: assert property (
        w0 |-> ##2 tok_gap_o[10:0] == $past(wdata_i[10:0], 2))
        else $error("token gap wrong");
    a_static_slot: assert property (
        s0 |-> ##2 fixed_forward_on_o[2] == $past(wdata_i[31], 2))
        else $error("static slot wrong");
    c_greet: cover property (w0 && wdata_i[24]);
    c_restart: cover property (w0 && wdata_i[23]);
    c_static: cover property (s0 && wdata_i[31]);
endmodule
bind lcsf_link_config lcsf_checker #(.NLINK(NLINK), .GAPW(GAPW)) chk_u (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .link_enable_o(link_enable_o),
    .pin_mux_sel_o(pin_mux_sel_o),
    .five_wire_select_o(five_wire_select_o),
    .send_greeting_token_o(send_greeting_token_o),
    .credit_clear_o(credit_clear_o),
    .receiver_restart_o(receiver_restart_o), .sym_gap_o(sym_gap_o),
    .tok_gap_o(tok_gap_o), .fixed_forward_on_o(fixed_forward_on_o));

/* File: lcsf_defines.vh */
`ifndef LCSF_DEFINES_VH
`define LCSF_DEFINES_VH
// ---------------------------------------------------------------
// register map (word addresses on the configuration port)
// ---------------------------------------------------------------
`define LCSF_LINK_BASE 8'h80
`define LCSF_STAT_BASE 8'ha0
`define LCSF_IRQ_STATUS 8'hc0
`define LCSF_IRQ_MASK 8'hc1
// ---------------------------------------------------------------
// link control/status field positions
// ---------------------------------------------------------------
`define LCSF_L_EN 31
`define LCSF_L_WIDE 30
`define LCSF_L_ERR 27
`define LCSF_L_RXCR 26
`define LCSF_L_TXCR 25
`define LCSF_L_HELLO 24
`define LCSF_L_RXRST 23
`define LCSF_L_SYM_HI 21
`define LCSF_L_SYM_LO 11
`define LCSF_L_TOK_HI 10
`define LCSF_L_TOK_LO 0
// ---------------------------------------------------------------
// static forwarding field positions
// ---------------------------------------------------------------
`define LCSF_S_EN 31
`define LCSF_S_CORE 8
`define LCSF_S_EP_HI 4
`define LCSF_S_EP_LO 0
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LCSF_GAP_RST 11'h000
`define LCSF_EP_RST 5'h00
`endif

/* File: lcsf_far_end.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// remote link end: answers a greeting DLY clocks after it is sampled
// ---------------------------------------------------------------
module lcsf_far_end #(
    parameter DLY = 4 // raise to model a slow far end
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire [7:0] greet_i,
    input wire [7:0] clear_i,
    input wire [7:0] enable_i,
    output reg [7:0] rx_credit_o,
    output reg [7:0] tx_credit_o
);
    reg [8*DLY-1:0] pipe_reg; // greetings in flight
    // credit only lives on enabled links; clear drops tx credit at once
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pipe_reg <= {8*DLY{1'b0}};
            rx_credit_o <= 8'h00;
            tx_credit_o <= 8'h00;
        end else begin
            pipe_reg <= {pipe_reg[8*DLY-9:0], greet_i};
            tx_credit_o <= (tx_credit_o & ~clear_i |
                pipe_reg[8*DLY-1 -: 8]) & enable_i;
            rx_credit_o <= (rx_credit_o | pipe_reg[8*DLY-1 -: 8]) &
                enable_i;
        end
    end
endmodule

/* File: lcsf_link_config.v */
// Functional notes
// - top bit enables or disables link
// - enable bit steers shared port muxing
// - bit 30 selects two/five wires
// - bit 27 flags overflow or illegal token
// - bit 26 shows credit granted remote
// - bit 25 shows credit held locally
// - bit 24 clears credit, sends greeting
// - bit 23 restarts receiver token framing
// - bits 21:11 inter-symbol gap minus one
// - bits 10:0 inter-token gap minus one
// - eight link registers, links zero-seven
// - static enable forwards all, no routing
// - static registers map C,D,A,B,G,H,E,F
// - static bit 8 picks core
// - static bits 4:0 pick endpoint
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "lcsf_defines.vh"

module lcsf_link_config #(
    parameter NLINK = 8,   // external links
    parameter GAPW = 11    // gap field width
) (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // per-link status from the link engines
    input wire [NLINK-1:0] rx_overflow_i,
    input wire [NLINK-1:0] rx_illegal_i,
    input wire [NLINK-1:0] rx_credit_given_i,
    input wire [NLINK-1:0] tx_credit_held_i,
    // per-link controls to the link engines
    output reg [NLINK-1:0] link_enable_o,
    output reg [NLINK-1:0] pin_mux_sel_o,
    output reg [NLINK-1:0] five_wire_select_o,
    output reg [NLINK-1:0] send_greeting_token_o,
    output reg [NLINK-1:0] credit_clear_o,
    output reg [NLINK-1:0] receiver_restart_o,
    output reg [NLINK*GAPW-1:0] sym_gap_o,
    output reg [NLINK*GAPW-1:0] tok_gap_o,
    // static forwarding, indexed by link number 0..7 (A=0 .. H=7)
    output reg [NLINK-1:0] fixed_forward_on_o,
    output reg [NLINK-1:0] fixed_forward_core_o,
    output reg [NLINK*5-1:0] fixed_forward_endpoint_o,
    output reg irq_o
);

// ---------------------------------------------------------------
// address decode helpers
// ---------------------------------------------------------------
// static slot order C,D,A,B,G,H,E,F -> link number
function [2:0] slot_to_link;
    input [2:0] slot;
    begin
        slot_to_link = {slot[2], ~slot[1], slot[0]};
    end
endfunction

// link number -> static slot (the map is its own inverse)
function [2:0] link_to_slot;
    input [2:0] lnk;
    begin
        link_to_slot = {lnk[2], ~lnk[1], lnk[0]};
    end
endfunction

// ---------------------------------------------------------------
// storage
// ---------------------------------------------------------------
reg [NLINK-1:0] en_reg;           // link enables
reg [NLINK-1:0] wide_reg;         // five-wire select
reg [NLINK-1:0] err_reg;          // sticky receive error
reg [GAPW-1:0] sym_reg [0:NLINK-1]; // inter-symbol gap
reg [GAPW-1:0] tok_reg [0:NLINK-1]; // inter-token gap
reg [NLINK-1:0] fon_reg;          // static forward enable
reg [NLINK-1:0] fcore_reg;        // static core
reg [4:0] fep_reg [0:NLINK-1];    // static endpoint
reg [NLINK-1:0] ist_reg;          // interrupt status
reg [NLINK-1:0] imask_reg;        // interrupt mask

wire lnk_hit = (addr_i[7:3] == 5'h10); // 0x80..0x87
wire sta_hit = (addr_i[7:3] == 5'h14); // 0xa0..0xa7
wire [2:0] idx = addr_i[2:0];
wire [2:0] sidx = slot_to_link(addr_i[2:0]);
wire [NLINK-1:0] err_evt = rx_overflow_i | rx_illegal_i;

integer k;

// ---------------------------------------------------------------
// register writes
// ---------------------------------------------------------------
// the error flag is read-only, so it clears only on a receiver
// restart write; it stays set until then to keep evidence
always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
        en_reg <= {NLINK{1'b0}};
        wide_reg <= {NLINK{1'b0}};
        err_reg <= {NLINK{1'b0}};
        fon_reg <= {NLINK{1'b0}};
        fcore_reg <= {NLINK{1'b0}};
        ist_reg <= {NLINK{1'b0}};
        imask_reg <= {NLINK{1'b0}};
        for (k = 0; k < NLINK; k = k + 1) begin
            sym_reg[k] <= `LCSF_GAP_RST;
            tok_reg[k] <= `LCSF_GAP_RST;
            fep_reg[k] <= `LCSF_EP_RST;
        end
    end else begin
        // receive error: set on event, restart clears, set wins
        for (k = 0; k < NLINK; k = k + 1) begin
            if (err_evt[k]) begin
                err_reg[k] <= 1'b1;
            end else if (wr_i && lnk_hit && idx == k &&
                         wdata_i[`LCSF_L_RXRST]) begin
                err_reg[k] <= 1'b0;
            end
        end
        // interrupt status: set wins over write-one-to-clear
        if (wr_i && addr_i == `LCSF_IRQ_STATUS) begin
            ist_reg <= (ist_reg & ~wdata_i[NLINK-1:0]) | err_evt;
        end else begin
            ist_reg <= ist_reg | err_evt;
        end
        if (wr_i && lnk_hit) begin
            // only writable fields stored
            en_reg[idx] <= wdata_i[`LCSF_L_EN];
            wide_reg[idx] <= wdata_i[`LCSF_L_WIDE];
            sym_reg[idx] <=
                wdata_i[`LCSF_L_SYM_HI:`LCSF_L_SYM_LO];
            tok_reg[idx] <=
                wdata_i[`LCSF_L_TOK_HI:`LCSF_L_TOK_LO];
        end else if (wr_i && sta_hit) begin
            fon_reg[sidx] <= wdata_i[`LCSF_S_EN];
            fcore_reg[sidx] <= wdata_i[`LCSF_S_CORE];
            fep_reg[sidx] <=
                wdata_i[`LCSF_S_EP_HI:`LCSF_S_EP_LO];
        end else if (wr_i && addr_i == `LCSF_IRQ_MASK) begin
            imask_reg <= wdata_i[NLINK-1:0];
        end
    end
end

// ---------------------------------------------------------------
// command pulses and registered outputs
// ---------------------------------------------------------------
// outputs come from flops: pulses appear one cycle after write
genvar g;
generate
    for (g = 0; g < NLINK; g = g + 1) begin : g_out
        wire hit = wr_i && lnk_hit && (idx == g);
        always @(posedge ref_clk_i) begin
            if (!resetn_i) begin
                send_greeting_token_o[g] <= 1'b0;
                credit_clear_o[g] <= 1'b0;
                receiver_restart_o[g] <= 1'b0;
                sym_gap_o[g*GAPW +: GAPW] <= `LCSF_GAP_RST;
                tok_gap_o[g*GAPW +: GAPW] <= `LCSF_GAP_RST;
                fixed_forward_endpoint_o[g*5 +: 5] <= `LCSF_EP_RST;
            end else begin
                // greeting also drops local credit
                send_greeting_token_o[g] <=
                    hit && wdata_i[`LCSF_L_HELLO];
                credit_clear_o[g] <= hit && wdata_i[`LCSF_L_HELLO];
                // next symbol begins a token
                receiver_restart_o[g] <= hit && wdata_i[`LCSF_L_RXRST];
                sym_gap_o[g*GAPW +: GAPW] <= sym_reg[g];
                tok_gap_o[g*GAPW +: GAPW] <= tok_reg[g];
                fixed_forward_endpoint_o[g*5 +: 5] <= fep_reg[g];
            end
        end
    end
endgenerate

// ---------------------------------------------------------------
// level outputs
// ---------------------------------------------------------------
always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
        link_enable_o <= {NLINK{1'b0}};
        pin_mux_sel_o <= {NLINK{1'b0}};
        five_wire_select_o <= {NLINK{1'b0}};
        fixed_forward_on_o <= {NLINK{1'b0}};
        fixed_forward_core_o <= {NLINK{1'b0}};
        irq_o <= 1'b0;
    end else begin
        link_enable_o <= en_reg;
        // shared pins follow the enabled link
        pin_mux_sel_o <= en_reg;
        five_wire_select_o <= wide_reg;
        fixed_forward_on_o <= fon_reg;
        fixed_forward_core_o <= fcore_reg;
        irq_o <= |(ist_reg & imask_reg);
    end
end

// ---------------------------------------------------------------
// read path, data valid the cycle after the strobe
// ---------------------------------------------------------------
reg [31:0] rd_next;
reg [2:0] rl;
always @* begin
    rd_next = 32'h0000_0000; // unmapped and reserved read zero
    rl = slot_to_link(addr_i[2:0]);
    if (lnk_hit) begin
        rd_next[`LCSF_L_EN] = en_reg[idx];
        rd_next[`LCSF_L_WIDE] = wide_reg[idx];
        rd_next[`LCSF_L_ERR] = err_reg[idx];
        rd_next[`LCSF_L_RXCR] = rx_credit_given_i[idx];
        rd_next[`LCSF_L_TXCR] = tx_credit_held_i[idx];
        rd_next[`LCSF_L_SYM_HI:`LCSF_L_SYM_LO] = sym_reg[idx];
        rd_next[`LCSF_L_TOK_HI:`LCSF_L_TOK_LO] = tok_reg[idx];
    end else if (sta_hit) begin
        rd_next[`LCSF_S_EN] = fon_reg[rl];
        rd_next[`LCSF_S_CORE] = fcore_reg[rl];
        rd_next[`LCSF_S_EP_HI:`LCSF_S_EP_LO] = fep_reg[rl];
    end else if (addr_i == `LCSF_IRQ_STATUS) begin
        rd_next[NLINK-1:0] = ist_reg;
    end else if (addr_i == `LCSF_IRQ_MASK) begin
        rd_next[NLINK-1:0] = imask_reg;
    end
end

always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
        rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
        rdata_o <= rd_next;
    end else begin
        rdata_o <= 32'h0000_0000;
    end
end

endmodule

/* File: link_config_static_forward_test.sv */
`timescale 1ns/1ps
module link_config_static_forward_test;
    logic clk = 0, rstn = 0, wr = 0, rd = 0;
    logic [7:0] addr = 0, ovf = 0, ill = 0, en, mux, wide, gr, clr, rs;
    logic [7:0] rxc, txc, ffon, ffcore;
    logic [31:0] wdat = 0, rdat, d;
    logic [87:0] sg, tg;
    logic [39:0] ffep;
    logic irq;
    logic [2:0] l;
    int bad_count = 0, n_compared = 0;
    // rows: address, write data, expected read back
    logic [31:0] rows [0:5][0:2] = '{'{32'h80, 32'hfe7fffff, 32'hc03fffff},
        '{32'h87, 32'h40000801, 32'h40000801},
        '{32'ha3, 32'hffffffff, 32'h8000011f},
        '{32'ha7, 32'h0000001f, 32'h0000001f},
        '{32'h90, 32'hffffffff, 32'h0}, '{32'hc1, 32'h3, 32'h3}};
    lcsf_link_config dut_u (.ref_clk_i(clk), .resetn_i(rstn),
        .addr_i(addr), .wdata_i(wdat), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdat), .rx_overflow_i(ovf), .rx_illegal_i(ill),
        .rx_credit_given_i(rxc), .tx_credit_held_i(txc),
        .link_enable_o(en), .pin_mux_sel_o(mux),
        .five_wire_select_o(wide), .send_greeting_token_o(gr),
        .credit_clear_o(clr), .receiver_restart_o(rs), .sym_gap_o(sg),
        .tok_gap_o(tg), .fixed_forward_on_o(ffon),
        .fixed_forward_core_o(ffcore), .fixed_forward_endpoint_o(ffep),
        .irq_o(irq));
    lcsf_far_end far_u (.ref_clk_i(clk), .resetn_i(rstn), .greet_i(gr),
        .clear_i(clr), .enable_i(en), .rx_credit_o(rxc),
        .tx_credit_o(txc));
    initial begin
        forever #25 clk = ~clk;
    end
    // bus tasks: strobe one cycle, change just after the edge
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 d = rdat;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // hang guard, far beyond the hundred or so cycles needed
    initial begin
        #2000000 bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        for (int i = 0; i < 6; i++) begin
            wr_reg(rows[i][0][7:0], rows[i][1]);
            rd_reg(rows[i][0][7:0]);
            chk("row", d, rows[i][2]);
        end
        chk("en", en, 8'h01);
        chk("mux", mux, 8'h01);
        chk("wide", wide, 8'h81);
        chk("sym", {sg[87:77], sg[10:0]}, {11'h1, 11'h7ff});
        chk("tok", {tg[87:77], tg[10:0]}, {11'h1, 11'h7ff});
        for (int s = 0; s < 8; s++) begin
            l = {s[2], ~s[1], s[0]};
            wr_reg({5'h14, s[2:0]}, {24'h800001, 5'h0, s[2:0]});
            settle;
            chk("ffon", ffon[l], 1);
            chk("ffcore", ffcore[l], 1);
            chk("ffep", ffep[l*5+:5], s[2:0]);
        end
        wr_reg(8'h80, 32'h81000000);
        #1 chk("greet", {gr[0], clr[0]}, 2'b11);
        repeat (8) @(posedge clk);
        rd_reg(8'h80);
        chk("credit", d[26:25], 2'b11);
        ovf <= 8'h01;
        @(posedge clk) ovf <= 8'h00;
        settle;
        chk("irq", irq, 1);
        rd_reg(8'h80);
        chk("err", d[27], 1);
        wr_reg(8'hc0, 32'h1);
        wr_reg(8'h80, 32'h80800000);
        #1 chk("restart", rs[0], 1);
        rd_reg(8'h80);
        chk("errclr", {d[27], irq}, 2'b00);
        ill <= 8'h04;
        @(posedge clk) ill <= 8'h00;
        settle;
        chk("masked", irq, 0);
        rd_reg(8'h82);
        chk("err2", d[27], 1);
        rstn <= 0;
        settle;
        rstn <= 1;
        rd_reg(8'h80);
        chk("rst", d, 32'h0);
        chk("rst_en", en, 8'h00);
        report_and_stop;
    end
endmodule
